// ### core/arop_pkg.sv
// Constants, layouts and types of the result output port
//
// Notes on behaviour
// - Mode 0 to 2 puts result bits on the shared pins; mode 3 gives them serial roles.
// - The stored result leaves the shift register MSB first, in the selected coding.
// - As serial master, data is stable across both edges of the serial clock.
// - As slave without clock inversion, data changes on the rising clock edge.
// - As slave with clock inversion, data changes on the falling clock edge.
// - The serial clock pin is driven in master mode and is an input in slave mode.
// - As master with frame polarity low, frame sync is high while data is valid.
// - As master with frame polarity high, frame sync is low while data is valid.
// - A slave read unfinished when a conversion completes is dropped and flagged.
// - The four top data pins are outputs in every interface mode.
// - Busy rises at conversion start and falls once the result is latched.
// - As master, read during conversion sends the previous result while busy.
// - As slave, the daisy-chain input reaches serial data 18 clocks after start.
package arop_pkg;

  // Result width and timing
  localparam int DW               = 18;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int CONV_TIME_NS     = 700;
  localparam int CONV_CYC         = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int RDERR_PULSE_CYC  = 8;
  localparam int SCLK_QUARTER_CYC = 2;

  // APB register offsets
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_INT_STAT = 8'h08;
  localparam logic [7:0]  ADDR_INT_MASK = 8'h0c;
  localparam logic [7:0]  ADDR_RESULT   = 8'h10;

  // Interrupt bit positions
  localparam int INT_W     = 3;
  localparam int INT_DONE  = 0;
  localparam int INT_RDERR = 1;
  localparam int INT_FRAME = 2;

  // Synchronised pin inputs
  localparam int IN_W    = 5;
  localparam int IN_CS   = 0;
  localparam int IN_RD   = 1;
  localparam int IN_CNV  = 2;
  localparam int IN_SCLK = 3;
  localparam int IN_DAISY_CHAIN_INPUT = 4;

  // Shared pin roles in serial mode
  localparam int         PAD_SDO    = 10;
  localparam int         PAD_SCLK   = 11;
  localparam int         PAD_SYNC   = 12;
  localparam int         PAD_RDERR  = 13;
  localparam int         PAD_HI_LSB = 14;
  localparam logic [1:0] MODE_SERIAL = 2'h3;

  // Control register layout, bit 6 downward
  typedef struct packed {
    logic       rd_during;   // bit 6
    logic       out_code;    // bit 5, high = straight binary
    logic       frame_pol;   // bit 4
    logic       clk_inv;     // bit 3
    logic       clk_src;     // bit 2, high = slave
    logic [1:0] mode;        // bits 1:0
  } arop_ctrl_s;
  localparam int         CTRL_W     = 7;
  localparam arop_ctrl_s CTRL_RESET = 7'h00;

  // Data pins with their output enables
  typedef struct packed {
    logic [DW-1:0] out;
    logic [DW-1:0] oe;
  } arop_pad_s;

  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} arop_state_e;

endpackage : arop_pkg

// ### core/arop_port.sv
// Result output port: busy timing, parallel and serial result delivery
`timescale 1ns/10ps
module arop_port #(
  parameter int CONV_CYC_P  = arop_pkg::CONV_CYC,
  parameter int QUARTER_P   = arop_pkg::SCLK_QUARTER_CYC,
  parameter int RDERR_CYC_P = arop_pkg::RDERR_PULSE_CYC
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [arop_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        chip_select_n,
  input  wire logic                        read_strobe_n,
  input  wire logic                        conversion_start_strobe,
  input  wire logic                        serial_clock_in,
  input  wire logic                        daisy_chain_input,
  input  wire logic [arop_pkg::DW-1:0]     adc_code,
  output arop_pkg::arop_pad_s              pads,
  output logic                             busy_out,
  output logic                             irq
);
  import arop_pkg::*;

  localparam int CONV_CW  = $clog2(CONV_CYC_P + 1);
  localparam int QCW      = $clog2(QUARTER_P + 1);
  localparam int RCW      = $clog2(RDERR_CYC_P + 1);

  arop_ctrl_s            ctrl_reg;
  logic [INT_W-1:0]      int_stat_reg;
  logic [INT_W-1:0]      int_mask_reg;
  logic [DW-1:0]         result_reg;
  logic                  busy_reg;
  logic [CONV_CW-1:0]    conv_cnt_reg;
  logic [IN_W-1:0]       meta_reg;
  logic [IN_W-1:0]       sync_reg;
  logic [IN_W-1:0]       prev_reg;
  arop_state_e           state_reg;
  logic [DW-1:0]         sh_reg;
  logic [4:0]            bit_cnt_reg;
  logic [QCW-1:0]        q_cnt_reg;
  logic [1:0]            ph_reg;
  logic [RCW-1:0]        rderr_cnt_reg;
  arop_pad_s             pad_reg;
  arop_pad_s             pad_next;
  logic                  irq_reg;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;

  logic                  bus_en;
  logic                  cnv_fall;
  logic                  active_edge;
  logic                  serial;
  logic                  conv_done;
  logic [DW-1:0]         coded;
  logic                  m_start;
  logic                  s_start;
  logic                  q_tick;
  logic                  frame_end;
  logic                  rd_abort;
  logic                  sclk_raw;
  logic                  sdo;
  logic                  apb_setup;
  logic                  apb_write;
  logic [INT_W-1:0]      int_clr;
  logic                  addr_ok;

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------

  // Two flops per pin, third flop keeps the last value for edges
  // Reset to the idle levels of the pins, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 5'h1f;
      sync_reg <= 5'h1f;
      prev_reg <= 5'h1f;
    end else begin
      meta_reg <= {daisy_chain_input, serial_clock_in,
                   conversion_start_strobe, read_strobe_n, chip_select_n};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Host clock is oversampled: its edges must be a few pclk apart or a
  // bit is lost
  // Decoded pin conditions
  assign bus_en   = ~sync_reg[IN_CS] & ~sync_reg[IN_RD];
  assign cnv_fall = prev_reg[IN_CNV] & ~sync_reg[IN_CNV];
  assign active_edge = ctrl_reg.clk_inv
    ? (prev_reg[IN_SCLK] & ~sync_reg[IN_SCLK])
    : (~prev_reg[IN_SCLK] & sync_reg[IN_SCLK]);
  assign serial    = (ctrl_reg.mode == MODE_SERIAL);
  assign conv_done = busy_reg && (conv_cnt_reg == '0);

  // Straight binary or two's complement of the converter code
  assign coded = ctrl_reg.out_code ? adc_code
               : {~adc_code[DW-1], adc_code[DW-2:0]};

  // ---------------------------------------------------------------
  // Conversion timing and busy
  // ---------------------------------------------------------------

  // A start edge while busy is dropped: the sample is already held
  // Result is latched in the same cycle busy clears, so its falling edge
  // can serve as data ready
  // Busy from start edge until result is latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg     <= 1'b0;
      conv_cnt_reg <= '0;
      result_reg   <= '0;
    end else if (!busy_reg && cnv_fall) begin
      busy_reg     <= 1'b1;
      conv_cnt_reg <= CONV_CW'(CONV_CYC_P - 1);
    end else if (conv_done) begin
      busy_reg     <= 1'b0;
      result_reg   <= coded;
    end else if (busy_reg) begin
      conv_cnt_reg <= conv_cnt_reg - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Serial frame engine
  // ---------------------------------------------------------------

  // Read during conversion loads the old word at the start edge, before
  // the new result overwrites it
  // Slave frames only start between conversions
  // Frame start conditions for master and slave
  assign m_start = serial && !ctrl_reg.clk_src && bus_en
                && (state_reg == ST_IDLE)
                && (ctrl_reg.rd_during ? (cnv_fall && !busy_reg)
                                       : conv_done);
  assign s_start = serial && ctrl_reg.clk_src && bus_en && !busy_reg
                && (state_reg == ST_IDLE);
  assign q_tick  = (q_cnt_reg == QCW'(QUARTER_P - 1));

  // Frame endings and the dropped read
  assign frame_end = ((state_reg == ST_MASTER) && q_tick && (ph_reg == 2'h3)
                      && (bit_cnt_reg == 5'(DW - 1)))
                  || ((state_reg == ST_SLAVE) && !bus_en
                      && (bit_cnt_reg == 5'(DW)));
  assign rd_abort  = (state_reg == ST_SLAVE) && bus_en && conv_done
                  && (bit_cnt_reg < 5'(DW));

  // Frame state, shift register and bit counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_IDLE;
      sh_reg      <= '0;
      bit_cnt_reg <= '0;
      q_cnt_reg   <= '0;
      ph_reg      <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          q_cnt_reg   <= '0;
          ph_reg      <= 2'h0;
          bit_cnt_reg <= '0;
          if (m_start) begin
            state_reg <= ST_MASTER;
            sh_reg    <= ctrl_reg.rd_during ? result_reg : coded;
          end else if (s_start) begin
            state_reg <= ST_SLAVE;
            sh_reg    <= result_reg;
          end
        end
        // Runs on if the bus drops; only the pin enables follow it
        ST_MASTER: begin
          if (!serial) begin
            state_reg <= ST_IDLE;
          end else if (q_tick) begin
            q_cnt_reg <= '0;
            ph_reg    <= ph_reg + 2'h1;
            // Data moves only at the bit boundary, clear of both edges
            if (ph_reg == 2'h3) begin
              if (frame_end) begin
                state_reg <= ST_IDLE;
                sh_reg    <= '0;
              end else begin
                sh_reg      <= {sh_reg[DW-2:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 5'h1;
              end
            end
          end else begin
            q_cnt_reg <= q_cnt_reg + 1'b1;
          end
        end
        ST_SLAVE: begin
          if (!serial || !bus_en || rd_abort) begin
            state_reg <= ST_IDLE;
          end else if (active_edge) begin
            // Daisy data follows the result bits out
            sh_reg <= {sh_reg[DW-2:0], sync_reg[IN_DAISY_CHAIN_INPUT]};
            if (bit_cnt_reg < 5'(DW)) begin
              bit_cnt_reg <= bit_cnt_reg + 5'h1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // A one-cycle flag is easily missed by a slow host, so it is held
  // Stretched read error pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rderr_cnt_reg <= '0;
    end else if (rd_abort) begin
      rderr_cnt_reg <= RCW'(RDERR_CYC_P);
    end else if (rderr_cnt_reg != '0) begin
      rderr_cnt_reg <= rderr_cnt_reg - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------

  assign sclk_raw = (ph_reg == 2'h1) || (ph_reg == 2'h2);
  assign sdo      = (state_reg == ST_IDLE) ? 1'b0 : sh_reg[DW-1];

  // Top four pins stay driven whatever the mode
  // Shared pin roles by interface mode
  always_comb begin
    pad_next.out = result_reg;
    pad_next.oe  = {DW{bus_en}};
    if (serial) begin
      pad_next.out = '0;
      pad_next.oe  = '0;
      pad_next.out[PAD_SDO] = sdo;
      pad_next.oe[PAD_SDO]  = bus_en;
      pad_next.out[PAD_SCLK] = ((state_reg == ST_MASTER) && sclk_raw)
                               ^ ctrl_reg.clk_inv;
      pad_next.oe[PAD_SCLK]  = !ctrl_reg.clk_src && bus_en;
      pad_next.out[PAD_SYNC] = (state_reg == ST_MASTER)
                               ^ ctrl_reg.frame_pol;
      pad_next.oe[PAD_SYNC]  = !ctrl_reg.clk_src && bus_en;
      pad_next.out[PAD_RDERR] = (rderr_cnt_reg != '0);
      pad_next.oe[PAD_RDERR]  = bus_en;
    end
    pad_next.out[DW-1:PAD_HI_LSB] = result_reg[DW-1:PAD_HI_LSB];
    pad_next.oe[DW-1:PAD_HI_LSB]  = '1;
  end

  // Pins come from flops so no decode glitch reaches the outside
  // Registered pins and busy output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_reg <= '0;
      pad_reg.oe[DW-1:PAD_HI_LSB] <= '1;
      busy_out <= 1'b0;
    end else begin
      pad_reg  <= pad_next;
      busy_out <= busy_reg;
    end
  end
  assign pads = pad_reg;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready_reg && pwrite;
  assign addr_ok   = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
                  || (paddr == ADDR_INT_STAT) || (paddr == ADDR_INT_MASK)
                  || (paddr == ADDR_RESULT);
  assign int_clr   = (apb_write && (paddr == ADDR_INT_STAT))
                     ? pwdata[INT_W-1:0] : '0;

  // No wait state; read data stands unchanged through access
  // Read data and answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup && !addr_ok;
      if (apb_setup && !pwrite) begin
        case (paddr)
          ADDR_CTRL:     prdata_reg <= {25'h0, ctrl_reg};
          ADDR_STATUS:   prdata_reg <= {24'h0, bit_cnt_reg, state_reg,
                                        busy_reg};
          ADDR_INT_STAT: prdata_reg <= {29'h0, int_stat_reg};
          ADDR_INT_MASK: prdata_reg <= {29'h0, int_mask_reg};
          ADDR_RESULT:   prdata_reg <= {14'h0, result_reg};
          default:       prdata_reg <= 32'h0;
        endcase
      end
    end
  end

  // Leaving serial mode mid-frame sends the frame engine back to idle
  // Control and mask writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= CTRL_RESET;
      int_mask_reg <= '0;
    end else if (apb_write) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_reg <= arop_ctrl_s'(pwdata[CTRL_W-1:0]);
      end
      if (paddr == ADDR_INT_MASK) begin
        int_mask_reg <= pwdata[INT_W-1:0];
      end
    end
  end

  // An event that meets its own clear stays set, so none is lost
  // Sticky events, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~int_clr)
                    | {frame_end, rd_abort, conv_done};
      irq_reg      <= |(int_stat_reg & int_mask_reg);
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

endmodule : arop_port

// ### verif/arop_port_monitor.sv
// Checker of the result output port pins
`timescale 1ns/10ps
module arop_port_monitor #(
  parameter int CONV_CYC_P = arop_pkg::CONV_CYC
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                conversion_start_strobe,
  input wire logic                chip_select_n,
  input wire logic                busy_out,
  input wire arop_pkg::arop_pad_s pads
);
  import arop_pkg::*;
  int unsigned busy_cnt;
  logic        ser;
  // Serial roles: no parallel bit driven
  assign ser = (pads.oe[9:0] == 10'h0);
  // Length of the busy level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_out ? busy_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_top_pins_out: assert property (pads.oe[17:14] == 4'hf)
    else $error("top pins undriven");
  chk_parallel_whole: assert property (
    !ser |-> pads.oe[13:0] == 14'h3fff) else $error("partial parallel bus");
  chk_bus_off: assert property (
    chip_select_n [*6] |-> pads.oe[13:0] == 14'h0) else $error("bus on");
  chk_sclk_role: assert property (
    ser |-> pads.oe[11] == pads.oe[12]) else $error("clock pin role");
  chk_data_steady: assert property (
    $changed(pads.out[10]) && pads.oe[11] && ser && $past(ser)
    |-> $stable(pads.out[11]) ##1 $stable(pads.out[11]))
    else $error("data moved at clock edge");
  chk_busy_start: assert property (
    $fell(conversion_start_strobe) && !busy_out |-> ##[3:6] busy_out)
    else $error("busy did not rise");
  chk_busy_len: assert property (
    $fell(busy_out) |-> busy_cnt == CONV_CYC_P) else $error("busy length");
  chk_flag_pulse: assert property (
    $rose(pads.out[13]) && ser && $past(ser)
    |-> pads.out[13] [*8] ##1 !pads.out[13]) else $error("flag width");
endmodule : arop_port_monitor

bind arop_port arop_port_monitor #(.CONV_CYC_P(CONV_CYC_P))
  i_arop_port_monitor (.pclk(pclk), .presetn(presetn),
  .conversion_start_strobe(conversion_start_strobe),
  .chip_select_n(chip_select_n), .busy_out(busy_out), .pads(pads));

// ### verif/arop_host_model.sv
// Host side serial reader for slave mode
`timescale 1ns/10ps
module arop_host_model (
  output logic      sclk,
  output logic      daisy,
  input  wire logic sdo
);
  localparam realtime HALF = 62.5;
  // Clock parked high, daisy level held high
  initial begin
    sclk = 1'b1;
    daisy = 1'b1;
  end
  // Park so that the next edge is the sampling one
  task automatic park(input logic inv);
    sclk = ~inv;
  endtask : park
  // Daisy level shifted in behind the result
  task automatic set_daisy(input logic v);
    daisy = v;
  endtask : set_daisy
  // Sample a bit, then shift the next one out
  task automatic read_bits(input logic inv, input int n,
                           output logic [19:0] got);
    got = 20'h0;
    for (int i = 0; i < n; i++) begin
      #HALF sclk = inv;
      got = {got[18:0], sdo};
      #HALF sclk = ~inv;
    end
  endtask : read_bits
endmodule : arop_host_model

// ### verif/arop_port_bench.sv
// Self-checking bench of the result output port
`timescale 1ns/10ps
module arop_port_bench;
  import arop_pkg::*;
  localparam int CONV  = 10;
  localparam int LIMIT = 30000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        chip_select_n, read_strobe_n, conversion_start_strobe;
  logic        sclk, daisy, busy_out, irq, rerr;
  logic [17:0] adc_code;
  arop_pad_s   pads;
  int          fails, check_count, cycles;

  arop_port #(.CONV_CYC_P(CONV)) i_arop_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n),
    .conversion_start_strobe(conversion_start_strobe),
    .serial_clock_in(sclk), .daisy_chain_input(daisy),
    .adc_code(adc_code), .pads(pads), .busy_out(busy_out), .irq(irq));
  arop_host_model i_arop_host_model (
    .sclk(sclk), .daisy(daisy),
    .sdo(pads.oe[PAD_SDO] ? pads.out[PAD_SDO] : ~pads.out[PAD_SDO]));

  // Clock and cycle ceiling
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: %h vs %h", $time, what, got, exp);
    end
  endtask : check

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rdat, rerr} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb

  // Start a conversion and wait for busy to fall
  task automatic convert(input logic [17:0] c);
    adc_code <= c;
    conversion_start_strobe <= 1'b0;
    while (busy_out !== 1'b1) @(posedge pclk);
    conversion_start_strobe <= 1'b1;
    while (busy_out !== 1'b0) @(posedge pclk);
  endtask : convert

  // Parallel modes, coding, enable, interrupt
  task automatic t_parallel();
    logic [17:0] e;
    apb(1'b1, 8'h14, 32'hffffffff);
    check(32'(rerr), 32'h1, "unmapped");
    {chip_select_n, read_strobe_n} <= 2'b00;
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, ADDR_CTRL, (m == 0) ? 32'h20 : 32'(m));
      convert(18'h2a5c3 + 18'(m));
      e = (m == 0) ? 18'h2a5c3 : (18'h2a5c3 + 18'(m)) ^ 18'h20000;
      repeat (2) @(posedge pclk);
      check(32'(pads.out), 32'(e), "parallel data");
      check(32'(pads.oe), 32'h3ffff, "parallel oe");
    end
    {chip_select_n, read_strobe_n} <= 2'b11;
    repeat (8) @(posedge pclk);
    check(32'(pads.oe), 32'h3c000, "bus off oe");
    apb(1'b1, ADDR_INT_STAT, 32'h7);
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    convert(18'h00155);
    repeat (3) @(posedge pclk);
    check(32'(irq), 32'h1, "irq raised");
    apb(1'b1, ADDR_INT_STAT, 32'h1);
    @(posedge pclk);
    check(32'(irq), 32'h0, "irq cleared");
  endtask : t_parallel

  // Master frame: sync level, count, order
  task automatic t_master(input logic pol, input logic rdd,
                          input logic [17:0] c, input logic [17:0] e);
    logic [17:0] got;
    logic        s_q;
    int          bits, n;
    {got, s_q, bits, n} = '0;
    apb(1'b1, ADDR_CTRL, {25'h0, rdd, 1'b1, pol, 4'h3});
    repeat (2) @(posedge pclk);
    fork
      convert(c);
      begin
        while (pads.out[12] !== ~pol && n++ < 400) @(posedge pclk);
        while (pads.out[12] === ~pol && n++ < 800) begin
          if (pads.out[11] && !s_q) begin
            got = {got[16:0], pads.out[10]};
            bits++;
          end
          s_q = pads.out[11];
          @(posedge pclk);
        end
      end
    join
    check(32'(bits), 32'd18, "master bits");
    check(32'(got), 32'(e), "master data");
    check(32'(pads.out[10]), 32'h0, "idle data");
  endtask : t_master

  // Slave read with either clock edge, then daisy bits
  task automatic t_slave(input logic inv, input logic [17:0] c,
                         input int n, input logic d);
    logic [19:0] g;
    {chip_select_n, read_strobe_n} <= 2'b11;
    i_arop_host_model.set_daisy(d);
    apb(1'b1, ADDR_CTRL, {25'h0, 3'h2, inv, 3'h7});
    i_arop_host_model.park(inv);
    convert(c);
    {chip_select_n, read_strobe_n} <= 2'b00;
    repeat (10) @(posedge pclk);
    check(32'(pads.oe[12:11]), 32'h0, "slave clock");
    i_arop_host_model.read_bits(inv, n, g);
    @(posedge pclk);
    if (n == 20) begin
      check(32'(g[19:2]), 32'(c), "slave data");
      check(32'(g[1:0]), 32'({d, d}), "daisy bits");
    end
  endtask : t_slave

  // Slave read cut short by a conversion
  task automatic t_rderr();
    apb(1'b1, ADDR_INT_STAT, 32'h7);
    t_slave(1'b0, 18'h00001, 5, 1'b1);
    convert(18'h00002);
    repeat (2) @(posedge pclk);
    check(32'(pads.out[13]), 32'h1, "read error flag");
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    check(rdat & 32'h2, 32'h2, "read error status");
  endtask : t_rderr

  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h0;
    {paddr, pwdata, adc_code} = '0;
    {chip_select_n, read_strobe_n, conversion_start_strobe} = 3'h7;
    {fails, check_count, cycles} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdat, 32'h0, "ctrl reset");
    t_parallel();
    {chip_select_n, read_strobe_n} <= 2'b00;
    t_master(1'b0, 1'b0, 18'h3c0f1, 18'h3c0f1);
    t_master(1'b1, 1'b0, 18'h0f0f5, 18'h0f0f5);
    t_master(1'b0, 1'b1, 18'h12345, 18'h0f0f5);
    t_slave(1'b1, 18'h2c3a5, 20, 1'b0);
    t_slave(1'b0, 18'h1b7e9, 20, 1'b1);
    t_rderr();
    results();
  end
endmodule : arop_port_bench
